/* flash_cmd.v */
// serial flash read and erase command sequencer
`include "flash_cmd_map.vh"
module flash_cmd #(
    parameter SMALL_ERASE_CYCLES = `SMALL_ERASE_MS * `CLK_KHZ,
    parameter SECTOR_ERASE_CYCLES = `SECTOR_ERASE_MS * `CLK_KHZ
) (
    input wire clk,
    input wire resetn,
    input wire cs_n,
    input wire sck,
    input wire data_line_0_in,
    output reg data_line_0_out,
    output reg data_line_0_oe_n,
    input wire data_line_1_in,
    output reg data_line_1_out,
    output reg data_line_1_oe_n,
    output reg rd_req_valid,
    output reg [23:0] rd_req_addr,
    input wire rd_req_ready,
    input wire rd_data_valid,
    input wire [7:0] rd_data,
    output reg rd_data_ready,
    output reg erase_valid,
    output reg erase_small,
    output reg [23:0] erase_addr,
    input wire erase_ready,
    output reg busy,
    output reg write_enable_latch
);
// ----------------------------------------
// synchronisers and edges
// ----------------------------------------
reg [1:0] cs_s_q, sck_s_q, d0_s_q, d1_s_q;
reg cs_d_q, sck_d_q;
wire cs_lo = ~cs_s_q[1];
wire sck_rise = sck_s_q[1] & ~sck_d_q;
wire sck_fall = ~sck_s_q[1] & sck_d_q;
wire cs_rise = cs_s_q[1] & ~cs_d_q;
always @(posedge clk) begin
    if (!resetn) begin
        cs_s_q <= 2'h3;
        sck_s_q <= 2'h0;
        d0_s_q <= 2'h0;
        d1_s_q <= 2'h0;
        cs_d_q <= 1'h1;
        sck_d_q <= 1'h0;
    end else begin
        cs_s_q <= {cs_s_q[0], cs_n};
        sck_s_q <= {sck_s_q[0], sck};
        d0_s_q <= {d0_s_q[0], data_line_0_in};
        d1_s_q <= {d1_s_q[0], data_line_1_in};
        cs_d_q <= cs_s_q[1];
        sck_d_q <= sck_s_q[1];
    end
end
// ----------------------------------------
// two-entry read data buffer
// ----------------------------------------
reg [7:0] buf_q [0:1];
reg buf_wp_q, buf_rp_q;
reg [1:0] buf_cnt_q;
wire buf_full = buf_cnt_q == 2'h2;
wire buf_empty = buf_cnt_q == 2'h0;
// push only on a real handshake, so a word offered to a full buffer is held, not lost
wire buf_push = rd_data_valid & rd_data_ready;
wire buf_pop;
// ----------------------------------------
// command state
// ----------------------------------------
localparam ST_IDLE = 3'h0, ST_CMD = 3'h1, ST_ADDR = 3'h2, ST_DUMMY = 3'h3;
localparam ST_DATA = 3'h4, ST_DONE = 3'h5;
reg [2:0] st_q;
reg [5:0] clk_cnt_q;
reg [7:0] op_q;
reg [23:0] addr_q;
reg [7:0] shift_q;
reg [2:0] bit_cnt_q;
reg dual_q;
reg [22:0] timer_q;

function [23:0] next_addr;
    input [23:0] a;
    begin
        next_addr = (a + 24'h000001) & `ADDR_WRAP_MASK;
    end
endfunction

wire is_dual_io = op_q == `OP_DUAL_IO_READ;
wire is_read = (op_q == `OP_FAST_READ) | (op_q == `OP_DUAL_OUT_READ) | is_dual_io;
wire is_erase = (op_q == `OP_SMALL_ERASE_A) | (op_q == `OP_SMALL_ERASE_B)
                | (op_q == `OP_SECTOR_ERASE);
wire [5:0] addr_end = is_dual_io ? `CNT_DUAL_ADDR_END : `CNT_ADDR_END;
wire [5:0] data_start = is_dual_io ? `CNT_DUAL_IO_DATA : `CNT_FAST_DATA;

function [23:0] erase_base;
    input sector;
    input [23:0] a;
    begin
        if (sector)
            erase_base = {4'h0, a[19:16], 16'h0000};
        else
            erase_base = {4'h0, a[19:12], 12'h000};
    end
endfunction

wire data_fall = cs_lo & sck_fall & is_read & (clk_cnt_q >= data_start);
wire first_fall = clk_cnt_q == data_start;
wire byte_start = data_fall & ((bit_cnt_q == 3'h0) | first_fall);
wire addr_done = cs_lo & sck_rise & (clk_cnt_q == addr_end);
// a new read drops whatever the last one prefetched past its end
wire buf_flush = addr_done & is_read;
assign buf_pop = byte_start & ~buf_empty;
wire [1:0] buf_cnt_d = buf_flush ? 2'h0 : buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
// an empty buffer sends all ones rather than stall the link
wire [7:0] buf_head = buf_empty ? 8'hFF : buf_q[buf_rp_q];
wire erase_ok = cs_rise & is_erase & (clk_cnt_q == `CNT_ADDR_END) & write_enable_latch & ~busy;

// ----------------------------------------
// serial sequence and pins
// ----------------------------------------
always @(posedge clk) begin
    if (!resetn) begin
        st_q <= ST_IDLE;
        clk_cnt_q <= 6'h00;
        op_q <= 8'h00;
        addr_q <= 24'h000000;
        shift_q <= 8'h00;
        bit_cnt_q <= 3'h0;
        dual_q <= 1'b0;
        data_line_0_out <= 1'b0;
        data_line_1_out <= 1'b0;
        data_line_0_oe_n <= 1'b1;
        data_line_1_oe_n <= 1'b1;
        rd_req_valid <= 1'b0;
        rd_req_addr <= 24'h000000;
    end else begin
        if (rd_req_valid & rd_req_ready) begin
            rd_req_valid <= 1'b0;
        end
        if (!cs_lo) begin
            data_line_0_oe_n <= 1'b1;
            data_line_1_oe_n <= 1'b1;
            st_q <= ST_IDLE;
            clk_cnt_q <= 6'h00;
            dual_q <= 1'b0;
        end
        if (cs_rise) begin
            op_q <= 8'h00;
        end
        if (cs_lo && sck_rise) begin
            // saturates so a long read never wraps back into the opcode phase
            if (clk_cnt_q != 6'h3F) begin
                clk_cnt_q <= clk_cnt_q + 6'h01;
            end
            if (clk_cnt_q < `CNT_OPCODE_END) begin
                op_q <= {op_q[6:0], d0_s_q[1]};
                st_q <= ST_CMD;
            end else if (clk_cnt_q < addr_end) begin
                st_q <= ST_ADDR;
                if (is_dual_io) begin
                    addr_q <= {addr_q[21:0], d1_s_q[1], d0_s_q[1]};
                end else begin
                    addr_q <= {addr_q[22:0], d0_s_q[1]};
                end
            end else if (clk_cnt_q < data_start) begin
                st_q <= ST_DUMMY;
            end
            // first fetch on the next sck rise after the address is complete
            if (addr_done && is_read) begin
                rd_req_valid <= 1'b1;
                rd_req_addr <= addr_q & `ADDR_WRAP_MASK;
            end
        end
        // first bit on the fall ending clock 40 or 24
        if (data_fall) begin
            if (first_fall) begin
                st_q <= ST_DATA;
                dual_q <= op_q != `OP_FAST_READ;
                data_line_1_oe_n <= 1'b0;
                data_line_0_oe_n <= op_q == `OP_FAST_READ;
            end
            if (byte_start) begin
                shift_q <= buf_head;
                rd_req_valid <= 1'b1;
                rd_req_addr <= next_addr(first_fall ? addr_q : rd_req_addr);
                data_line_1_out <= buf_head[7];
                if (op_q == `OP_FAST_READ) begin
                    bit_cnt_q <= 3'h7;
                end else begin
                    data_line_0_out <= buf_head[6];
                    bit_cnt_q <= 3'h3;
                end
            end else begin
                bit_cnt_q <= bit_cnt_q - 3'h1;
                if (dual_q) begin
                    data_line_1_out <= shift_q[(bit_cnt_q << 1) - 3'h1];
                    data_line_0_out <= shift_q[(bit_cnt_q << 1) - 3'h2];
                end else begin
                    data_line_1_out <= shift_q[bit_cnt_q - 3'h1];
                end
            end
        end
    end
end

// ----------------------------------------
// write enable and erase timer
// ----------------------------------------
always @(posedge clk) begin
    if (!resetn) begin
        erase_valid <= 1'b0;
        erase_small <= 1'b0;
        erase_addr <= 24'h000000;
        busy <= 1'b0;
        write_enable_latch <= 1'b0;
        timer_q <= 23'h000000;
    end else begin
        if (erase_valid & erase_ready) begin
            erase_valid <= 1'b0;
        end
        if (busy) begin
            if (timer_q == 23'h000000) begin
                busy <= 1'b0;
            end else begin
                timer_q <= timer_q - 23'h000001;
            end
        end
        if (cs_rise && op_q == `OP_WRITE_ENABLE && clk_cnt_q == `CNT_OPCODE_END) begin
            write_enable_latch <= 1'b1;
        end
        if (erase_ok) begin
            erase_valid <= 1'b1;
            erase_small <= op_q != `OP_SECTOR_ERASE;
            erase_addr <= erase_base(op_q == `OP_SECTOR_ERASE, addr_q);
            busy <= 1'b1;
            timer_q <= (op_q == `OP_SECTOR_ERASE) ? SECTOR_ERASE_CYCLES[22:0]
                                                  : SMALL_ERASE_CYCLES[22:0];
            write_enable_latch <= 1'b0;
        end
    end
end

// ----------------------------------------
// read data buffer pointers
// ----------------------------------------
always @(posedge clk) begin
    if (!resetn) begin
        buf_wp_q <= 1'b0;
        buf_rp_q <= 1'b0;
        buf_cnt_q <= 2'h0;
        rd_data_ready <= 1'b0;
    end else begin
        // ready follows the next count, so a full buffer never takes a word
        rd_data_ready <= buf_cnt_d != 2'h2;
        buf_cnt_q <= buf_cnt_d;
        if (buf_flush) begin
            buf_wp_q <= 1'b0;
            buf_rp_q <= 1'b0;
        end else begin
            if (buf_push) begin
                buf_wp_q <= ~buf_wp_q;
            end
            if (buf_pop) begin
                buf_rp_q <= ~buf_rp_q;
            end
        end
    end
end

always @(posedge clk) begin
    if (buf_push) begin
        buf_q[buf_wp_q] <= rd_data;
    end
end
endmodule

/* flash_cmd_map.vh */
// constants for the serial flash read and erase command logic
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH
// ----------------------------------------
// opcodes
// ----------------------------------------
`define OP_FAST_READ 8'h0B
`define OP_DUAL_OUT_READ 8'h3B
`define OP_DUAL_IO_READ 8'hBB
`define OP_SMALL_ERASE_A 8'h20
`define OP_SMALL_ERASE_B 8'hD7
`define OP_SECTOR_ERASE 8'hD8
`define OP_WRITE_ENABLE 8'h06
// ----------------------------------------
// sequence counts (serial clocks after chip select falls)
// ----------------------------------------
`define CNT_OPCODE_END 6'h08
`define CNT_ADDR_END 6'h20
`define CNT_FAST_DATA 6'h28
`define CNT_DUAL_ADDR_END 6'h14
`define CNT_DUAL_IO_DATA 6'h18
`define ADDR_WRAP_MASK 24'h0FFFFF
// ----------------------------------------
// erase timing
// ----------------------------------------
`define SMALL_ERASE_MS 10
`define SECTOR_ERASE_MS 15
`define CLK_KHZ 40000
`endif

/* flash_cmd_chk.sv */
// concurrent checks on the flash command sequencer ports
module flash_cmd_chk (
    input wire clk,
    input wire resetn,
    input wire cs_n,
    input wire data_line_0_oe_n,
    input wire data_line_1_oe_n,
    input wire rd_req_valid,
    input wire [23:0] rd_req_addr,
    input wire rd_req_ready,
    input wire erase_valid,
    input wire erase_small,
    input wire [23:0] erase_addr,
    input wire erase_ready,
    input wire busy,
    input wire write_enable_latch
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------
    // properties
    // ----------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_DESELECT_HIZ:
    assert property (cs_n [*8] |-> data_line_0_oe_n && data_line_1_oe_n) else $error("pin driven");
    AST_ERASE_WEL:
    assert property ($rose(erase_valid) |-> $past(write_enable_latch)) else $error("no latch");
    AST_ERASE_HOLD:
    assert property (erase_valid && !erase_ready |=> erase_valid && $stable(erase_addr)) else $error("erase drop");
    AST_SMALL_ALIGN:
    assert property (erase_valid && erase_small |-> erase_addr[11:0] == 12'h000) else $error("small align");
    AST_SECTOR_ALIGN:
    assert property (erase_valid && !erase_small |-> erase_addr[15:0] == 16'h0000) else $error("sect align");
    AST_BUSY_START:
    assert property (erase_valid && erase_ready |-> ##[0:4] busy) else $error("no busy");
    AST_RDREQ_HOLD:
    assert property (rd_req_valid && !rd_req_ready |=> rd_req_valid && $stable(rd_req_addr)) else $error("req drop");
    AST_ADDR_WRAP:
    assert property (rd_req_valid |-> rd_req_addr[23:20] == 4'h0) else $error("addr past top");
    cover property (erase_valid && erase_ready && erase_small);
    cover property (erase_valid && erase_ready && !erase_small);
    cover property (rd_req_valid && rd_req_ready && !data_line_0_oe_n);
endmodule
bind flash_cmd flash_cmd_chk chk (.clk(clk), .resetn(resetn), .cs_n(cs_n), .busy(busy),
    .data_line_0_oe_n(data_line_0_oe_n), .data_line_1_oe_n(data_line_1_oe_n),
    .rd_req_valid(rd_req_valid), .rd_req_addr(rd_req_addr), .rd_req_ready(rd_req_ready),
    .erase_valid(erase_valid), .erase_small(erase_small), .erase_addr(erase_addr),
    .erase_ready(erase_ready), .write_enable_latch(write_enable_latch));

/* flash_host_model.sv */
// spi host model in mode 0 for the flash command sequencer
module flash_host_model (
    input wire clk,
    input wire o0,
    input wire e0_n,
    input wire o1,
    input wire e1_n,
    output reg cs_n = 1'b1,
    output reg sck = 1'b0,
    output wire line0,
    output wire line1,
    output reg [7:0] rx_byte = 8'h00,
    output reg [7:0] rx_seq = 8'h00
);
    timeunit 1ns;
    timeprecision 100ps;
    reg [1:0] hd = 2'b00;
    reg [1:0] hv = 2'b00;
    // released lines float up on pull-ups
    assign line0 = !e0_n ? o0 : hv[0] ? hd[0] : 1'b1;
    assign line1 = !e1_n ? o1 : hv[1] ? hd[1] : 1'b1;
    // sampled late in the high phase, since the answer lags the fall
    task automatic tick(input [1:0] d, input [1:0] v, output [1:0] r);
        sck <= 1'b0;
        hd <= d;
        hv <= v;
        repeat (4) @(posedge clk);
        sck <= 1'b1;
        repeat (4) @(posedge clk);
        r = {line1, line0};
    endtask
    // cs held low, raised with sck low
    task automatic frame(input [7:0] op, input [23:0] a, input integer abits, input integer n);
        reg [1:0] r;
        reg [7:0] b;
        integer i, k;
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (i = 7; i >= 0; i--) tick({1'b0, op[i]}, 2'b01, r);
        if (op == 8'hBB) begin
            for (i = 23; i > 0; i -= 2) tick(a[i -: 2], 2'b11, r);
            for (i = 0; i < 4; i++) tick(2'b00, i < 2 ? 2'b11 : 2'b00, r);
        end else begin
            for (i = 23; i >= 24 - abits; i--) tick({1'b0, a[i]}, 2'b01, r);
            for (i = 0; i < 8 && n > 0; i++) tick(2'b00, 2'b01, r);
        end
        for (k = 0; k < n; k++) begin
            for (i = 0; i < 8; i += (op == 8'h0B) ? 1 : 2) begin
                tick(2'b00, 2'b00, r);
                b = (op == 8'h0B) ? {b[6:0], r[1]} : {b[5:0], r};
            end
            rx_byte <= b;
            rx_seq <= rx_seq + 8'h01;
        end
        sck <= 1'b0;
        hv <= 2'b00;
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        repeat (12) @(posedge clk);
    endtask
endmodule

/* flash_cmd_tb.sv */
// self-checking bench for the flash command sequencer
module flash_cmd_tb;
    timeunit 1ns;
    timeprecision 100ps;
    reg clk = 1'b0, resetn = 1'b0, rd_req_ready = 1'b0, rd_data_valid = 1'b0, erase_ready = 1'b0;
    reg [7:0] rd_data = 8'h00, seen = 8'h00;
    reg [31:0] rnd = 32'h8B7C;
    reg [23:0] a;
    reg [25:0] q[$];
    wire cs_n, sck, line0, line1, o0, e0, o1, e1, rv, dr, ev, es, busy, wel;
    wire [23:0] ra, ea;
    wire [7:0] rx_byte, rx_seq;
    integer fails = 0, compares = 0, cyc = 0, k;
    flash_cmd #(.SMALL_ERASE_CYCLES(20), .SECTOR_ERASE_CYCLES(20)) dut (.clk(clk), .resetn(resetn),
        .cs_n(cs_n), .sck(sck), .data_line_0_in(line0), .data_line_0_out(o0), .data_line_0_oe_n(e0),
        .data_line_1_in(line1), .data_line_1_out(o1), .data_line_1_oe_n(e1), .rd_req_valid(rv),
        .rd_req_addr(ra), .rd_req_ready(rd_req_ready), .rd_data_valid(rd_data_valid),
        .rd_data(rd_data), .rd_data_ready(dr), .erase_valid(ev), .erase_small(es), .erase_addr(ea),
        .erase_ready(erase_ready), .busy(busy), .write_enable_latch(wel));
    flash_host_model host (.clk(clk), .o0(o0), .e0_n(e0), .o1(o1), .e1_n(e1), .cs_n(cs_n),
        .sck(sck), .line0(line0), .line1(line1), .rx_byte(rx_byte), .rx_seq(rx_seq));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [7:0] mem(input [23:0] x);
        mem = x[7:0] ^ x[15:8] ^ 8'h5A;
    endfunction
    task check(input string what, input [25:0] got, input [25:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task final_report;
        if (fails == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task rd(input [7:0] op, input [23:0] x, input integer n);
        for (k = 0; k < n; k++) q.push_back({18'h0, mem((x + k) & 24'h0FFFFF)});
        host.frame(op, x, 24, n);
    endtask
    // -----------------------------------------
    // clock, memory side with random stalls
    // -----------------------------------------
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        rnd <= lfsr(rnd);
        erase_ready <= rnd[1];
        // one fetch outstanding, so a stall never drops a byte
        rd_req_ready <= rnd[0] && !rd_data_valid && !(rv && rd_req_ready);
        if (!rd_data_valid || dr) begin
            rd_data_valid <= rv && rd_req_ready;
            rd_data <= mem(ra);
        end
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
        if (rx_seq != seen) begin
            seen <= rx_seq;
            check("read byte", {18'h0, rx_byte}, q.size() ? q.pop_front() : 26'h3FFFFFF);
        end
        if (ev && erase_ready) check("erase", {1'b1, es, ea}, q.size() ? q.pop_front() : 26'h0);
    end
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(8'h0B, 24'h0FFFFE, 3);
        rd(8'h3B, rnd[23:0] & 24'h0FFFFF, 2);
        rd(8'hBB, rnd[31:8] & 24'h0FFFFF, 2);
        host.frame(8'h20, 24'h012345, 24, 0);
        for (int j = 0; j < 3; j++) begin
            a = rnd[23:0] & 24'h0FFFFF;
            host.frame(8'h06, a, 0, 0);
            check("latch", {25'h0, wel}, 26'h1);
            q.push_back(j == 2 ? {2'b10, a[23:16], 16'h0000} : {2'b11, a[23:12], 12'h000});
            host.frame(j == 0 ? 8'h20 : j == 1 ? 8'hD7 : 8'hD8, a, 24, 0);
            for (k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clk);
            check("busy", {25'h0, busy}, 26'h0);
        end
        host.frame(8'h06, a, 0, 0);
        host.frame(8'hD8, a, 16, 0);
        repeat (100) @(posedge clk);
        check("pending", 26'(q.size()), 26'h0);
        final_report();
    end
endmodule
